/* File: verilog/dma_pkg.sv */
// What this block does
// - memory access drives memory strobe low
// - I/O access drives I/O strobe low
// - I/O-paced transfers use request, signal end
// - I/O access: one automatic wait plus programmed/external waits
// - memory-mapped I/O gets no automatic wait
// - channel 0 memory copy ignores request input
// - burst keeps bus; steal alternates CPU cycle
// - 64KB crossing adds one idle state
// - channel 0 wins simultaneous requests
// - channel 1 idle during channel 0 copy
// - channel 0 waits until channel 1 releases
// - external bus request suspends at access boundary
// - resume suspended transfer, pending write included
// - count zero clears run enable until rewritten
// - done interrupt level while run clear, enabled
// - non-maskable interrupt clears master enable
// - interrupt suspends after current cycle ends
// - run enable write resumes suspended point
// - reset stops transfer, frees bus, resets control
// - reset keeps addresses and byte counts
// - channel end low during final write
// - request sampled before T3, decides continuation
// - run write needs mask low; copy starts later
package dma_pkg;
    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          CPU_CYCLE_NS   = 300;
    localparam logic [1:0]  CPU_CYCLE_CLKS = 2'((CPU_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0]  AUTO_IO_WAITS  = 3'h1;
    localparam int          CROSS_BIT      = 16;
    localparam logic [15:0] COUNT_DONE     = 16'h0000;
    localparam logic [1:0]  RUN_RESET      = 2'h0;
    localparam logic [1:0]  IRQ_EN_RESET   = 2'h0;
    localparam logic        MASTER_RESET   = 1'b0;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01, ST_TI = 7'h02, ST_T1 = 7'h04, ST_T2 = 7'h08,
        ST_TW = 7'h10, ST_T3 = 7'h20, ST_STEAL = 7'h40
    } bus_state_e;
    typedef enum logic [2:0] {
        XFER_MEM_MEM = 3'h0, XFER_MEM_IO = 3'h1, XFER_IO_MEM = 3'h2, XFER_MEM_MMIO = 3'h3, XFER_MMIO_MEM = 3'h4
    } ch0_mode_e;
    typedef enum logic [1:0] {STEP_INC = 2'h0, STEP_DEC = 2'h1, STEP_FIX = 2'h2} step_e;
    typedef enum logic [2:0] {
        LD_CH0_SRC = 3'h0, LD_CH0_DST = 3'h1, LD_CH1_MEM = 3'h2, LD_CH1_IO = 3'h3, LD_CH0_COUNT = 3'h4, LD_CH1_COUNT = 3'h5
    } load_sel_e;

    typedef struct packed {
        ch0_mode_e  ch0_mode;
        step_e      ch0_src_step;
        step_e      ch0_dst_step;
        logic       ch0_burst;
        logic       ch1_io_to_mem;
        step_e      ch1_mem_step;
        logic [1:0] wait_count;
    } cfg_s;
    typedef struct packed {
        logic       run_write;
        logic [1:0] run_value;
        logic [1:0] write_mask_n;
        logic       irq_en_write;
        logic [1:0] irq_en_value;
    } ctrl_s;
    typedef struct packed {
        logic       valid;
        load_sel_e  sel;
        logic [19:0] value;
    } load_s;
endpackage : dma_pkg

/* File: verilog/dma_bus_timing_priority_control.sv */
`timescale 1ns/1ps
module dma_bus_timing_priority_control
    import dma_pkg::*;
(
    input  logic        clk_sys_in,
    input  logic        reset_in,
    input  cfg_s        cfg_in,
    input  ctrl_s       ctrl_in,
    input  load_s       load_in,
    input  logic        ch0_request_n_in,
    input  logic        ch1_request_n_in,
    input  logic        bus_request_n_in,
    input  logic        wait_n_in,
    input  logic        nmi_accept_in,
    input  logic        cpu_irq_enable_flag_in,
    input  logic [7:0]  data_in,
    output logic [19:0] addr_out,
    output logic [7:0]  data_out,
    output logic        mem_request_n_out,
    output logic        io_request_n_out,
    output logic        read_n_out,
    output logic        write_n_out,
    output logic        bus_grant_n_out,
    output logic        dma_bus_owner_out,
    output logic        ch0_end_n_out,
    output logic        ch1_end_n_out,
    output logic        chan0_run_enable_out,
    output logic        chan1_run_enable_out,
    output logic [1:0]  chan_done_irq_enable_out,
    output logic        master_dma_enable_out,
    output logic        dma_irq_out
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    bus_state_e  state, next_state;
    logic        phase_wr, next_phase_wr;
    logic        cur_ch, next_cur_ch;
    logic [2:0]  wait_left, next_wait;
    logic [1:0]  steal_cnt, next_steal;
    logic [1:0]  start_delay, next_delay;
    logic        cross_pending, next_cross;
    logic        keep_going, next_keep;
    logic [1:0]  run, next_run;
    logic [1:0]  irq_en, next_irq_en;
    logic        master, next_master;
    logic [7:0]  next_data;
    logic [19:0] ch0_src, next_ch0_src;
    logic [19:0] ch0_dst, next_ch0_dst;
    logic [19:0] ch1_mem, next_ch1_mem;
    logic [15:0] ch1_io, next_ch1_io;
    logic [15:0] ch0_count, next_ch0_count;
    logic [15:0] ch1_count, next_ch1_count;
    logic        cross_now, cur_io, nxt_io, in_cycle, suspend, m2m0, elig0, elig1, go;
    logic [19:0] cur_addr, upd_addr, nxt_addr;

    function automatic logic acc_is_io(input logic ch, input logic wr, input cfg_s c);
        if (ch) begin
            acc_is_io = wr ? !c.ch1_io_to_mem : c.ch1_io_to_mem;
        end else begin
            acc_is_io = wr ? (c.ch0_mode == XFER_MEM_IO) : (c.ch0_mode == XFER_IO_MEM);
        end
    endfunction : acc_is_io

    function automatic logic [19:0] step_addr(input logic [19:0] a, input step_e s);
        unique case (s)
            STEP_INC: step_addr = a + 20'h00001;
            STEP_DEC: step_addr = a - 20'h00001;
            default:  step_addr = a;
        endcase
    endfunction : step_addr

    // ----------------------------------------------------------------
    // channel selection
    // ----------------------------------------------------------------
    assign m2m0    = (cfg_in.ch0_mode == XFER_MEM_MEM);
    // memory copy is self-timed; the request pin is not looked at
    assign elig0   = run[0] && (m2m0 ? (start_delay == 2'h0) : !ch0_request_n_in);
    assign elig1   = run[1] && !ch1_request_n_in && !(run[0] && m2m0);
    assign suspend = !master || !bus_request_n_in;
    assign go      = master && bus_request_n_in && (phase_wr ? run[cur_ch] : (elig0 || elig1));
    assign cur_io  = acc_is_io(cur_ch, phase_wr, cfg_in);
    assign cur_addr = cur_ch ? ((phase_wr == cfg_in.ch1_io_to_mem) ? ch1_mem : {4'h0, ch1_io})
                             : (phase_wr ? ch0_dst : ch0_src);

    // ----------------------------------------------------------------
    // address and count registers
    // ----------------------------------------------------------------
    always_comb begin
        next_ch0_src   = ch0_src;
        next_ch0_dst   = ch0_dst;
        next_ch1_mem   = ch1_mem;
        next_ch1_io    = ch1_io;
        next_ch0_count = ch0_count;
        next_ch1_count = ch1_count;
        if (state == ST_T3) begin
            if (!cur_ch && !phase_wr) begin
                next_ch0_src   = step_addr(ch0_src, cfg_in.ch0_src_step);
                next_ch0_count = ch0_count - 16'h0001;
            end
            if (!cur_ch && phase_wr) begin
                next_ch0_dst = step_addr(ch0_dst, cfg_in.ch0_dst_step);
            end
            if (cur_ch && !phase_wr) begin
                next_ch1_count = ch1_count - 16'h0001;
            end
            if (cur_ch && (phase_wr == cfg_in.ch1_io_to_mem)) begin
                next_ch1_mem = step_addr(ch1_mem, cfg_in.ch1_mem_step);
            end
        end
        if (load_in.valid) begin
            unique case (load_in.sel)
                LD_CH0_SRC:   next_ch0_src   = load_in.value;
                LD_CH0_DST:   next_ch0_dst   = load_in.value;
                LD_CH1_MEM:   next_ch1_mem   = load_in.value;
                LD_CH1_IO:    next_ch1_io    = load_in.value[15:0];
                LD_CH0_COUNT: next_ch0_count = load_in.value[15:0];
                LD_CH1_COUNT: next_ch1_count = load_in.value[15:0];
                default:      next_ch0_src   = ch0_src;
            endcase
        end
    end

    assign upd_addr  = cur_ch ? next_ch1_mem : (phase_wr ? next_ch0_dst : next_ch0_src);
    assign cross_now = (state == ST_T3) && !cur_io && (upd_addr[CROSS_BIT] != cur_addr[CROSS_BIT]);

    // no reset here: software contents survive a reset
    always_ff @(posedge clk_sys_in) begin
        ch0_src   <= next_ch0_src;
        ch0_dst   <= next_ch0_dst;
        ch1_mem   <= next_ch1_mem;
        ch1_io    <= next_ch1_io;
        ch0_count <= next_ch0_count;
        ch1_count <= next_ch1_count;
    end

    // ----------------------------------------------------------------
    // bus sequencer and control bits
    // ----------------------------------------------------------------
    always_comb begin
        next_state    = state;
        next_phase_wr = phase_wr;
        next_cur_ch   = cur_ch;
        next_wait     = wait_left;
        next_steal    = steal_cnt;
        next_delay    = (start_delay != 2'h0) ? start_delay - 2'h1 : start_delay;
        next_cross    = cross_pending;
        next_keep     = keep_going;
        next_run      = run;
        next_irq_en   = irq_en;
        next_master   = master;
        next_data     = data_out;
        unique case (state)
            ST_IDLE: begin
                // arbitration only here, so a running channel 1 keeps the bus
                if (go) begin
                    if (!phase_wr) begin
                        next_cur_ch = !elig0;
                    end
                    next_state = cross_pending ? ST_TI : ST_T1;
                end
            end
            ST_TI: begin
                next_cross = 1'b0;
                next_state = ST_T1;
            end
            ST_T1: begin
                next_wait  = (cur_io ? AUTO_IO_WAITS : 3'h0) + {1'b0, cfg_in.wait_count};
                next_state = ST_T2;
            end
            ST_T2, ST_TW: begin
                if (state == ST_TW && wait_left != 3'h0) begin
                    next_wait = wait_left - 3'h1;
                end
                if ((state == ST_T2 && wait_left != 3'h0) || (state == ST_TW && wait_left > 3'h1) || !wait_n_in) begin
                    next_state = ST_TW;
                end else begin
                    next_state = ST_T3;
                    next_keep  = !(cur_ch ? ch1_request_n_in : ch0_request_n_in);
                end
            end
            ST_T3: begin
                next_cross = cross_now;
                if (!phase_wr) begin
                    next_data     = data_in;
                    next_phase_wr = 1'b1;
                    next_state    = suspend ? ST_IDLE : (cross_now ? ST_TI : ST_T1);
                end else begin
                    next_phase_wr = 1'b0;
                    if ((cur_ch ? ch1_count : ch0_count) == COUNT_DONE) begin
                        next_run[cur_ch] = 1'b0;
                        next_state       = ST_IDLE;
                    end else if (suspend) begin
                        next_state = ST_IDLE;
                    end else if (cur_ch || !m2m0) begin
                        next_state = keep_going ? (cross_now ? ST_TI : ST_T1) : ST_IDLE;
                    end else if (cfg_in.ch0_burst) begin
                        next_state = cross_now ? ST_TI : ST_T1;
                    end else begin
                        next_steal = CPU_CYCLE_CLKS - 2'h1;
                        next_state = ST_STEAL;
                    end
                end
            end
            ST_STEAL: begin
                next_steal = steal_cnt - 2'h1;
                if (steal_cnt == 2'h0) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
        if (nmi_accept_in) begin
            next_master = 1'b0;
        end
        // a software set lands after the hardware clear, so the set wins
        for (int i = 0; i < 2; i++) begin
            if (ctrl_in.run_write && !ctrl_in.write_mask_n[i]) begin
                next_run[i] = ctrl_in.run_value[i];
                if (ctrl_in.run_value[i]) begin
                    next_master = 1'b1;
                    if (i == 0) begin
                        next_delay = CPU_CYCLE_CLKS;
                    end
                end
            end
        end
        if (ctrl_in.irq_en_write) begin
            next_irq_en = ctrl_in.irq_en_value;
        end
    end

    assign in_cycle = (next_state == ST_T1) || (next_state == ST_T2) || (next_state == ST_TW) || (next_state == ST_T3);
    assign nxt_io   = acc_is_io(next_cur_ch, next_phase_wr, cfg_in);
    assign nxt_addr = next_cur_ch ? ((next_phase_wr == cfg_in.ch1_io_to_mem) ? next_ch1_mem : {4'h0, next_ch1_io})
                                  : (next_phase_wr ? next_ch0_dst : next_ch0_src);

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            state                    <= ST_IDLE;
            phase_wr                 <= 1'b0;
            cur_ch                   <= 1'b0;
            wait_left                <= 3'h0;
            steal_cnt                <= 2'h0;
            start_delay              <= 2'h0;
            cross_pending            <= 1'b0;
            keep_going               <= 1'b0;
            run                      <= RUN_RESET;
            irq_en                   <= IRQ_EN_RESET;
            master                   <= MASTER_RESET;
            data_out                 <= 8'h00;
            addr_out                 <= 20'h00000;
            mem_request_n_out        <= 1'b1;
            io_request_n_out         <= 1'b1;
            read_n_out               <= 1'b1;
            write_n_out              <= 1'b1;
            bus_grant_n_out          <= 1'b1;
            dma_bus_owner_out        <= 1'b0;
            ch0_end_n_out            <= 1'b1;
            ch1_end_n_out            <= 1'b1;
            dma_irq_out              <= 1'b0;
        end else begin
            state                    <= next_state;
            phase_wr                 <= next_phase_wr;
            cur_ch                   <= next_cur_ch;
            wait_left                <= next_wait;
            steal_cnt                <= next_steal;
            start_delay              <= next_delay;
            cross_pending            <= next_cross;
            keep_going               <= next_keep;
            run                      <= next_run;
            irq_en                   <= next_irq_en;
            master                   <= next_master;
            data_out                 <= next_data;
            addr_out                 <= in_cycle ? nxt_addr : addr_out;
            mem_request_n_out        <= !(in_cycle && !nxt_io);
            io_request_n_out         <= !(in_cycle && nxt_io);
            read_n_out               <= !(in_cycle && !next_phase_wr);
            write_n_out              <= !(in_cycle && next_phase_wr);
            dma_bus_owner_out        <= (next_state != ST_IDLE) && (next_state != ST_STEAL);
            bus_grant_n_out          <= !(next_state == ST_IDLE && !bus_request_n_in);
            ch0_end_n_out            <= !(in_cycle && next_phase_wr && !next_cur_ch && !m2m0
                                          && next_ch0_count == COUNT_DONE);
            ch1_end_n_out            <= !(in_cycle && next_phase_wr && next_cur_ch
                                          && next_ch1_count == COUNT_DONE);
            dma_irq_out              <= cpu_irq_enable_flag_in && |(~next_run & next_irq_en);
        end
    end

    assign chan0_run_enable_out     = run[0];
    assign chan1_run_enable_out     = run[1];
    assign chan_done_irq_enable_out = irq_en;
    assign master_dma_enable_out    = master;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_mem_strobe: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (state == ST_T2 && !cur_io) |-> !mem_request_n_out && io_request_n_out)
        else $error("memory strobe not low in memory access");
    chk_io_strobe: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (state == ST_T2 && cur_io) |-> !io_request_n_out && mem_request_n_out)
        else $error("io strobe not low in io access");
    chk_io_wait: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (state == ST_T2 && cur_io) |=> state == ST_TW)
        else $error("io access lacks its wait state");
    chk_mmio_nowait: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (state == ST_T1 && !cur_io && cfg_in.wait_count == 2'h0) ##1 wait_n_in |=> state == ST_T3)
        else $error("memory access got an unasked wait");
    chk_cross_idle: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (state == ST_TI) |=> state == ST_T1 ##1 state == ST_T2 ##1 (state == ST_T3 || state == ST_TW))
        else $error("crossing cycle shorter than four clocks");
    chk_ch0_first: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (state == ST_IDLE && go && !phase_wr && elig0 && elig1) |=> !cur_ch && state != ST_IDLE)
        else $error("channel 1 served before channel 0");
    chk_done_clear: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (state == ST_T3 && phase_wr && (cur_ch ? ch1_count : ch0_count) == COUNT_DONE && !ctrl_in.run_write)
        |=> !run[$past(cur_ch)] && state == ST_IDLE)
        else $error("run enable not cleared at count zero");
    chk_nmi_stop: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (nmi_accept_in && !ctrl_in.run_write) |=> !master_dma_enable_out)
        else $error("nmi left master enable set");
    chk_bus_request_n_yield: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (state == ST_T3 && !bus_request_n_in) |=> state == ST_IDLE ##1 !bus_grant_n_out || bus_request_n_in)
        else $error("bus not handed over at access boundary");
    chk_end_final: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (state == ST_T2 && phase_wr && !cur_ch && !m2m0 && ch0_count == COUNT_DONE) |-> !ch0_end_n_out)
        else $error("end output not low in final write");
endmodule : dma_bus_timing_priority_control

/* File: test/dma_bus_partner.sv */
`timescale 1ns/1ps
module dma_bus_partner (
    input  wire logic        clk_sys_in,
    input  wire logic        slow_in,
    input  wire logic [19:0] addr_in,
    input  wire logic [7:0]  wr_byte_in,
    input  wire logic        mem_request_n_in,
    input  wire logic        io_request_n_in,
    input  wire logic        read_n_in,
    input  wire logic        write_n_in,
    output logic      [7:0]  data_out,
    output logic             wait_n_out,
    output logic      [7:0]  wr_data_out,
    output int               wr_total_out
);
    logic [2:0] low_cnt = 3'h0;
    logic [1:0] rw_d    = 2'h3;
    logic [7:0] last    = 8'h00;
    int         wr_count = 0;
    logic       act;
    assign act = (!mem_request_n_in || !io_request_n_in) && (!read_n_in || !write_n_in);
    assign wr_total_out = wr_count;
    // a released bus shows the inverse of the last byte, never a held copy
    assign data_out = (act && !read_n_in) ? (addr_in[7:0] ^ 8'hA5) : ~last;
    // slow answer: one wait request in the second cycle of each access
    assign wait_n_out = !(slow_in && act && low_cnt == 3'h1);
    always @(posedge clk_sys_in) begin
        rw_d <= {read_n_in, write_n_in};
        low_cnt <= ({read_n_in, write_n_in} == rw_d) ? low_cnt + 3'h1 : 3'h1;
        if (act && !read_n_in) last <= data_out;
        if (act && !write_n_in) begin
            wr_data_out <= wr_byte_in;
            last <= wr_byte_in;
            if (rw_d[0]) wr_count <= wr_count + 1;
        end
    end
endmodule : dma_bus_partner

/* File: test/dma_bus_timing_priority_control_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
`define AWAIT(c) begin for (k = 0; k < 300 && !(c); k++) tick(1); if (!(c)) begin err_total++; results(); end end
module dma_bus_timing_priority_control_tb_top;
    import dma_pkg::*;
    typedef struct packed {
        ch0_mode_e  mode;
        logic [1:0] wc;
        logic       slow;
        logic [3:0] width;
        logic       io;
    } row_s;
    localparam row_s ROWS [6] = '{
        '{XFER_MEM_IO, 2'h0, 1'b0, 4'h4, 1'b1}, '{XFER_MEM_IO, 2'h2, 1'b0, 4'h6, 1'b1},
        '{XFER_MEM_MMIO, 2'h0, 1'b0, 4'h3, 1'b0}, '{XFER_MEM_MMIO, 2'h1, 1'b0, 4'h4, 1'b0},
        '{XFER_MEM_MMIO, 2'h0, 1'b1, 4'h4, 1'b0}, '{XFER_IO_MEM, 2'h0, 1'b0, 4'h3, 1'b0}};
    logic clk_sys_in = 1'b0, reset_in = 1'b1, req0 = 1'b1, req1 = 1'b1, bus_request_n = 1'b1;
    logic nmi = 1'b0, flag = 1'b0, slow = 1'b0, wait_n, mem_request_n, io_request_n, rd, wr, grant, owner;
    logic end0, end1, run0, run1, master, irq;
    logic [1:0]  irq_en;
    logic [7:0]  din, dout, wdata;
    logic [19:0] addr;
    cfg_s  cfg = '0;
    ctrl_s ctrl = '0;
    load_s ld = '0;
    int    err_total = 0, check_count = 0, wr_total;

    always #50 clk_sys_in = ~clk_sys_in;

    dma_bus_timing_priority_control dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .cfg_in(cfg),
        .ctrl_in(ctrl), .load_in(ld), .ch0_request_n_in(req0), .ch1_request_n_in(req1),
        .bus_request_n_in(bus_request_n), .wait_n_in(wait_n), .nmi_accept_in(nmi), .cpu_irq_enable_flag_in(flag),
        .data_in(din), .addr_out(addr), .data_out(dout), .mem_request_n_out(mem_request_n), .io_request_n_out(io_request_n),
        .read_n_out(rd), .write_n_out(wr), .bus_grant_n_out(grant), .dma_bus_owner_out(owner),
        .ch0_end_n_out(end0), .ch1_end_n_out(end1), .chan0_run_enable_out(run0),
        .chan1_run_enable_out(run1), .chan_done_irq_enable_out(irq_en), .master_dma_enable_out(master),
        .dma_irq_out(irq));
    dma_bus_partner far_side (.clk_sys_in(clk_sys_in), .slow_in(slow), .addr_in(addr), .wr_byte_in(dout),
        .mem_request_n_in(mem_request_n), .io_request_n_in(io_request_n), .read_n_in(rd), .write_n_in(wr),
        .data_out(din), .wait_n_out(wait_n), .wr_data_out(wdata), .wr_total_out(wr_total));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #10;
    endtask : tick
    task automatic results;
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    task automatic load(input load_sel_e s, input logic [19:0] v);
        ld = '{1'b1, s, v};
        tick(1);
        ld.valid = 1'b0;
    endtask : load
    task automatic run(input logic [1:0] v, input logic [1:0] m);
        ctrl = '{1'b1, v, m, 1'b0, 2'h0};
        tick(1);
        ctrl.run_write = 1'b0;
    endtask : run
    task automatic ch0(input logic [19:0] s, input logic [19:0] d, input logic [19:0] n);
        load(LD_CH0_SRC, s);
        load(LD_CH0_DST, d);
        load(LD_CH0_COUNT, n);
    endtask : ch0

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int k, w, gap, base;
        tick(20);
        `CHK({mem_request_n, io_request_n, rd, wr, grant, run0, master, irq}, 8'hF8)
        reset_in = 1'b0;
        flag = 1'b1;
        for (int i = 0; i < 6; i++) begin
            cfg.ch0_mode = ROWS[i].mode;
            cfg.wait_count = ROWS[i].wc;
            slow = ROWS[i].slow;
            ch0(20'h00140 + 20'(i), 20'h00180 + 20'(i), 20'h1);
            run(2'b01, 2'b10);
            req0 = 1'b0;
            `AWAIT(!wr)
            for (w = 0; w < 15 && !wr; w++) begin
                `CHK({io_request_n, mem_request_n, end0}, {!ROWS[i].io, ROWS[i].io, 1'b0})
                tick(1);
            end
            `CHK(4'(w), ROWS[i].width)
            `CHK(wdata, (8'h40 + 8'(i)) ^ 8'hA5)
            `CHK(run0, 1'b0)
            req0 = 1'b1;
        end
        // copies across a 64KB line pay one idle state before the write
        cfg = '0;
        cfg.ch0_burst = 1'b1;
        slow = 1'b0;
        ctrl = '{1'b0, 2'h0, 2'h3, 1'b1, 2'h1};
        tick(1);
        ctrl.irq_en_write = 1'b0;
        for (int i = 0; i < 2; i++) begin
            ch0(20'h0FFFE + 20'(i), 20'h00200, 20'h1);
            run(2'b01, 2'b10);
            for (w = 0; w < 20 && rd; w++) tick(1);
            `CHK(4'(w), 4'h4)
            `AWAIT(rd)
            for (gap = 0; gap < 9 && wr; gap++) tick(1);
            `CHK(gap, i)
            `CHK(mem_request_n, 1'b0)
            tick(5);
            `CHK({run0, irq, wdata}, {2'b01, (8'hFE + 8'(i)) ^ 8'hA5})
        end
        flag = 1'b0;
        tick(2);
        `CHK(irq, 1'b0)
        // done enable goes off before the cpu flag returns, so no stale request follows
        ctrl = '{1'b0, 2'h0, 2'h3, 1'b1, 2'h0};
        tick(1);
        ctrl.irq_en_write = 1'b0;
        flag = 1'b1;
        tick(1);
        `CHK({irq_en, irq}, 3'b000)
        base = wr_total;
        ch0(20'h00300, 20'h00280, 20'h3);
        run(2'b01, 2'b10);
        `AWAIT(!rd)
        bus_request_n = 1'b0;
        `AWAIT(!grant)
        tick(4);
        `CHK({mem_request_n, rd, wr, owner}, 4'hE)
        bus_request_n = 1'b1;
        `AWAIT(!run0)
        tick(3);
        `CHK(wr_total - base, 3)
        `CHK(wdata, 8'h02 ^ 8'hA5)
        cfg.ch0_mode = XFER_MEM_IO;
        load(LD_CH1_MEM, 20'h00400);
        load(LD_CH1_IO, 20'h00120);
        load(LD_CH1_COUNT, 20'h1);
        ch0(20'h00500, 20'h00130, 20'h1);
        run(2'b11, 2'b00);
        req0 = 1'b0;
        req1 = 1'b0;
        `AWAIT(!rd)
        `CHK(addr, 20'h00500)
        `AWAIT(!wr && addr == 20'h00120)
        `CHK({end1, end0, io_request_n, run1}, 4'b0101)
        `AWAIT(!run0 && !run1)
        tick(6);
        `CHK(wr_total - base, 5)
        req0 = 1'b1;
        req1 = 1'b1;
        cfg.ch0_mode = XFER_MEM_MEM;
        cfg.ch0_burst = 1'b0;
        ch0(20'h00600, 20'h00680, 20'h4);
        run(2'b01, 2'b10);
        `AWAIT(!wr)
        nmi = 1'b1;
        tick(1);
        nmi = 1'b0;
        tick(10);
        `CHK({master, mem_request_n, run0}, 3'b011)
        run(2'b01, 2'b10);
        `AWAIT(!wr)
        `AWAIT(wr)
        for (gap = 0; gap < 9 && rd; gap++) tick(1);
        `CHK(gap, 4)
        `AWAIT(!run0)
        tick(3);
        `CHK({wr_total - base, wdata}, {32'd9, 8'h03 ^ 8'hA5})
        ch0(20'h00700, 20'h00780, 20'h4);
        run(2'b01, 2'b10);
        `AWAIT(!rd)
        reset_in = 1'b1;
        tick(2);
        `CHK({mem_request_n, rd, wr, owner, run0, master}, 6'h38)
        reset_in = 1'b0;
        results();
    end
endmodule : dma_bus_timing_priority_control_tb_top
